// file: hw/cma_cfg.svh
// Purpose: constants of the core memory addressing and status block
// Assumes: included by the package, by the core module and by the checker
// Notes: offsets are 7-bit bank offsets, 16-bit pointer addresses or 8-bit APB register offsets
`ifndef CMA_CFG_SVH
`define CMA_CFG_SVH
`define CMA_DATA_W 8
`define CMA_NIB_W 4
`define CMA_STACK_DEPTH 16
`define CMA_STACK_CW 5
`define CMA_STACK_AW 4
`define CMA_PC_W 15
`define CMA_PM_AW 13
`define CMA_PM_DW 14
`define CMA_RESET_VEC 15'h0000
`define CMA_IRQ_VEC 15'h0004
`define CMA_PC_ONE 15'h0001
`define CMA_BANK_W 5
`define CMA_OFF_W 7
`define CMA_IDX_W 12
`define CMA_SFR_LO 7'h0C
`define CMA_GPR_LO 7'h20
`define CMA_COM_LO 7'h70
`define CMA_GPR_PER_BANK 12'h050
`define CMA_GPR_SIZE 2560
`define CMA_COM_SIZE 16
`define CMA_BANKED_HI 16'h0FFF
`define CMA_LIN_LO 16'h2000
`define CMA_LIN_HI 16'h29AF
`define CMA_PM_BIT 15
`define CMA_CORE_INDF0 7'h00
`define CMA_CORE_INDF1 7'h01
`define CMA_CORE_PCL 7'h02
`define CMA_CORE_STATUS 7'h03
`define CMA_CORE_FSR0L 7'h04
`define CMA_CORE_FSR0H 7'h05
`define CMA_CORE_FSR1L 7'h06
`define CMA_CORE_FSR1H 7'h07
`define CMA_CORE_BSR 7'h08
`define CMA_CORE_WORKING_REG 7'h09
`define CMA_CORE_PCLATH 7'h0A
`define CMA_CORE_INTCON 7'h0B
`define CMA_APB_STATUS 8'h00
`define CMA_APB_POWER_CONTROL_REG 8'h04
`define CMA_APB_PC 8'h08
`define CMA_APB_FSR 8'h0C
`define CMA_APB_BANK 8'h10
`define CMA_POWER_CONTROL_REG_OVF 0
`define CMA_POWER_CONTROL_REG_UNF 1
`define CMA_POWER_CONTROL_REG_RSTEN 2
`endif

// file: hw/cma_pkg.sv
// Purpose: types shared by the core memory addressing block
// Assumes: constants come from cma_cfg.svh
// Notes: nothing here holds state
`include "cma_cfg.svh"
package cma_pkg;
  typedef enum logic [2:0] {REG_NONE, REG_CORE, REG_SFR, REG_GPR, REG_COMMON, REG_PROG}
    cma_region_t;
  typedef struct packed {
    cma_region_t region;
    logic [`CMA_IDX_W-1:0] idx;
  } cma_mem_ref_t;
  typedef enum logic [2:0] {PC_HOLD, PC_INC, PC_JUMP, PC_CALL, PC_RET, PC_IRQ} cma_pc_op_t;
  typedef enum logic [1:0] {ALU_ADD, ALU_SUB, ALU_LOGIC} cma_alu_op_t;
  typedef struct packed {
    logic en;
    cma_alu_op_t op;
    logic [`CMA_DATA_W-1:0] a;
    logic [`CMA_DATA_W-1:0] b;
    logic [`CMA_DATA_W-1:0] result;
  } cma_alu_req_t;
  typedef struct packed {
    logic re;
    logic we;
    logic [`CMA_OFF_W-1:0] addr;
    logic [`CMA_DATA_W-1:0] wdata;
  } cma_file_req_t;
  typedef struct packed {
    logic z;
    logic dc;
    logic c;
  } cma_flags_t;
  typedef enum logic {IND_IDLE, IND_FETCH} cma_ind_state_t;
endpackage : cma_pkg

// file: hw/cma_core_mem.sv
// Purpose: return stack, program counter, pointers, banked RAM and status
// Assumes: program memory read is combinational on progAddr
// Notes: decoder holds its request while fileStall is high
//
// Implementation choices: the APB slave port and the address map.
`include "cma_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module cma_core_mem (
  // Clock and power-on reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Other resets and core events
  input wire logic softReset,
  input wire logic clrwdtExec,
  input wire logic sleepExec,
  input wire logic wdtTimeout,
  output logic stackResetReq,
  // Program counter control and program memory
  input wire cma_pkg::cma_pc_op_t pcOp,
  input wire logic [`CMA_PC_W-1:0] pcTarget,
  output logic [`CMA_PC_W-1:0] pcValue,
  output logic [`CMA_PM_AW-1:0] progAddr,
  input wire logic [`CMA_PM_DW-1:0] progData,
  // File register port
  input wire cma_pkg::cma_file_req_t fileReq,
  output logic [`CMA_DATA_W-1:0] fileRdata,
  output logic fileStall,
  output logic [`CMA_DATA_W-1:0] workReg,
  // ALU flag source
  input wire cma_pkg::cma_alu_req_t aluReq,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // Pointer space to storage; shared by direct and indirect paths
  function automatic cma_pkg::cma_mem_ref_t decodeAddr(input logic [15:0] a);
    cma_pkg::cma_mem_ref_t r;
    logic [`CMA_OFF_W-1:0] off;
    logic [`CMA_IDX_W-1:0] bankBase;
    r.region = cma_pkg::REG_NONE;
    r.idx = '0;
    off = a[`CMA_OFF_W-1:0];
    bankBase = `CMA_IDX_W'(a[`CMA_IDX_W-1:`CMA_OFF_W]) * `CMA_GPR_PER_BANK;
    if (a[`CMA_PM_BIT])
    begin
      r.region = cma_pkg::REG_PROG;
    end
    else if (a <= `CMA_BANKED_HI)
    begin
      if (off < `CMA_SFR_LO)
      begin
        r.region = cma_pkg::REG_CORE;
        r.idx = `CMA_IDX_W'(off);
      end
      else if (off < `CMA_GPR_LO)
      begin
        r.region = cma_pkg::REG_SFR;
      end
      else if (off < `CMA_COM_LO)
      begin
        r.region = cma_pkg::REG_GPR;
        r.idx = bankBase + `CMA_IDX_W'(off - `CMA_GPR_LO);
      end
      else
      begin
        r.region = cma_pkg::REG_COMMON;
        r.idx = `CMA_IDX_W'(off - `CMA_COM_LO);
      end
    end
    else if (a >= `CMA_LIN_LO && a <= `CMA_LIN_HI)
    begin
      r.region = cma_pkg::REG_GPR;
      r.idx = `CMA_IDX_W'(a - `CMA_LIN_LO);
    end
    return r;
  endfunction : decodeAddr

  // State
  logic [`CMA_PC_W-1:0] pc_reg;
  logic [`CMA_PC_W-1:0] stackMem [`CMA_STACK_DEPTH];
  logic [`CMA_STACK_CW-1:0] stackCount_reg;
  logic [15:0] fsr0_reg;
  logic [15:0] fsr1_reg;
  logic [`CMA_BANK_W-1:0] bsr_reg;
  logic [`CMA_DATA_W-1:0] working_reg_reg;
  logic [`CMA_DATA_W-1:0] pclath_reg;
  logic [`CMA_DATA_W-1:0] intcon_reg;
  logic to_reg;
  logic pd_reg;
  cma_pkg::cma_flags_t flags_reg;
  logic ovf_reg;
  logic unf_reg;
  logic stkRstEn_reg;
  cma_pkg::cma_ind_state_t ind_reg;
  cma_pkg::cma_ind_state_t ind_next;
  logic [`CMA_DATA_W-1:0] gprMem [`CMA_GPR_SIZE];
  logic [`CMA_DATA_W-1:0] comMem [`CMA_COM_SIZE];

  // Request decode
  logic isIndf;
  logic [15:0] selFsr;
  cma_pkg::cma_mem_ref_t effRef;
  logic pmReq;
  logic fileGo;
  logic wrGo;
  logic coreWr;
  cma_pkg::cma_pc_op_t pcAct;
  logic pushEvt;
  logic popEvt;
  logic ovfEvt;
  logic unfEvt;
  logic [`CMA_PC_W-1:0] stackTop;
  logic [`CMA_DATA_W-1:0] readMux;
  logic [`CMA_DATA_W-1:0] statusVal;
  cma_pkg::cma_flags_t newFlags;
  logic [`CMA_DATA_W-1:0] opB;
  logic cin;
  logic [`CMA_DATA_W:0] sum9;
  logic [`CMA_NIB_W:0] nib5;
  logic apbWr;
  logic apbMapped;
  logic [31:0] apbMux;

  // Indirect ports pick their pointer; direct accesses use the bank
  always_comb
  begin
    isIndf = (fileReq.addr == `CMA_CORE_INDF0) || (fileReq.addr == `CMA_CORE_INDF1);
    selFsr = (fileReq.addr == `CMA_CORE_INDF1) ? fsr1_reg : fsr0_reg;
    if (isIndf)
    begin
      effRef = decodeAddr(selFsr);
    end
    else
    begin
      effRef = decodeAddr(16'({bsr_reg, fileReq.addr}));
    end
    // A pointer aimed at a data port itself reads nothing
    if (isIndf && effRef.region == cma_pkg::REG_CORE &&
        effRef.idx[`CMA_OFF_W-1:1] == '0)
    begin
      effRef.region = cma_pkg::REG_NONE;
    end
  end

  // Program memory via pointer needs a fetch cycle
  assign pmReq = fileReq.re && isIndf && selFsr[`CMA_PM_BIT];
  assign fileStall = pmReq && (ind_reg == cma_pkg::IND_IDLE);
  assign fileGo = !fileStall;
  assign wrGo = fileReq.we && fileGo;
  assign coreWr = wrGo && effRef.region == cma_pkg::REG_CORE;

  // Fetch phase state
  always_comb
  begin
    case (ind_reg)
      cma_pkg::IND_IDLE: ind_next = pmReq ? cma_pkg::IND_FETCH : cma_pkg::IND_IDLE;
      cma_pkg::IND_FETCH: ind_next = cma_pkg::IND_IDLE;
      default: ind_next = cma_pkg::IND_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      ind_reg <= cma_pkg::IND_IDLE;
    else
      ind_reg <= ind_next;
  end

  // Program address: pointer during an indirect fetch, else the counter
  assign progAddr = pmReq ? selFsr[`CMA_PM_AW-1:0] : pc_reg[`CMA_PM_AW-1:0];
  assign pcValue = pc_reg;

  // Stalled instructions must not move the counter or stack
  assign pcAct = fileStall ? cma_pkg::PC_HOLD : pcOp;
  assign pushEvt = (pcAct == cma_pkg::PC_CALL) || (pcAct == cma_pkg::PC_IRQ);
  assign popEvt = (pcAct == cma_pkg::PC_RET);
  assign ovfEvt = pushEvt && (stackCount_reg == `CMA_STACK_CW'(`CMA_STACK_DEPTH));
  assign unfEvt = popEvt && (stackCount_reg == '0);
  assign stackTop = stackMem[`CMA_STACK_AW'(stackCount_reg - `CMA_STACK_CW'(1))];

  // Stack pointer; a full stack drops the push
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      stackCount_reg <= '0;
    else if (softReset)
      stackCount_reg <= '0;
    else if (pushEvt && !ovfEvt)
      stackCount_reg <= stackCount_reg + `CMA_STACK_CW'(1);
    else if (popEvt && !unfEvt)
      stackCount_reg <= stackCount_reg - `CMA_STACK_CW'(1);
  end

  // Stack storage; calls return past the call, interrupts to the same word
  always_ff @(posedge clk_sys)
  begin
    if (pushEvt && !ovfEvt && !softReset)
    begin
      if (pcAct == cma_pkg::PC_CALL)
        stackMem[`CMA_STACK_AW'(stackCount_reg)] <= pc_reg + `CMA_PC_ONE;
      else
        stackMem[`CMA_STACK_AW'(stackCount_reg)] <= pc_reg;
    end
  end

  // Program counter
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      pc_reg <= `CMA_RESET_VEC;
    else if (softReset)
      pc_reg <= `CMA_RESET_VEC;
    else
    begin
      case (pcAct)
        cma_pkg::PC_INC: pc_reg <= pc_reg + `CMA_PC_ONE;
        cma_pkg::PC_JUMP: pc_reg <= pcTarget;
        cma_pkg::PC_CALL: pc_reg <= pcTarget;
        cma_pkg::PC_RET: pc_reg <= unfEvt ? `CMA_RESET_VEC : stackTop;
        cma_pkg::PC_IRQ: pc_reg <= `CMA_IRQ_VEC;
        default: pc_reg <= pc_reg;
      endcase
    end
  end

  // Pointer, bank and plain core registers
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      fsr0_reg <= 16'h0000;
      fsr1_reg <= 16'h0000;
      bsr_reg <= '0;
      working_reg_reg <= 8'h00;
      pclath_reg <= 8'h00;
      intcon_reg <= 8'h00;
    end
    else if (coreWr)
    begin
      case (`CMA_OFF_W'(effRef.idx))
        `CMA_CORE_FSR0L: fsr0_reg[7:0] <= fileReq.wdata;
        `CMA_CORE_FSR0H: fsr0_reg[15:8] <= fileReq.wdata;
        `CMA_CORE_FSR1L: fsr1_reg[7:0] <= fileReq.wdata;
        `CMA_CORE_FSR1H: fsr1_reg[15:8] <= fileReq.wdata;
        `CMA_CORE_BSR: bsr_reg <= fileReq.wdata[`CMA_BANK_W-1:0];
        `CMA_CORE_WORKING_REG: working_reg_reg <= fileReq.wdata;
        `CMA_CORE_PCLATH: pclath_reg <= fileReq.wdata;
        `CMA_CORE_INTCON: intcon_reg <= fileReq.wdata;
        default: ;
      endcase
    end
  end
  assign workReg = working_reg_reg;

  // Flags from the add; subtract adds the inverted operand plus one
  always_comb
  begin
    cin = (aluReq.op == cma_pkg::ALU_SUB);
    opB = cin ? ~aluReq.b : aluReq.b;
    sum9 = {1'b0, aluReq.a} + {1'b0, opB} + (`CMA_DATA_W+1)'(cin);
    nib5 = {1'b0, aluReq.a[`CMA_NIB_W-1:0]} + {1'b0, opB[`CMA_NIB_W-1:0]} +
           (`CMA_NIB_W+1)'(cin);
    newFlags.c = sum9[`CMA_DATA_W];
    newFlags.dc = nib5[`CMA_NIB_W];
    if (aluReq.op == cma_pkg::ALU_LOGIC)
      newFlags.z = (aluReq.result == '0);
    else
      newFlags.z = (sum9[`CMA_DATA_W-1:0] == '0);
  end

  // Reset status flags; only hardware events move them
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      to_reg <= 1'b1;
      pd_reg <= 1'b1;
    end
    else
    begin
      if (wdtTimeout)
        to_reg <= 1'b0;
      else if (clrwdtExec || sleepExec)
        to_reg <= 1'b1;
      if (sleepExec)
        pd_reg <= 1'b0;
      else if (clrwdtExec)
        pd_reg <= 1'b1;
    end
  end

  // Arithmetic flags; operation result beats a data write to status
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      flags_reg <= '0;
    else if (aluReq.en)
    begin
      flags_reg.z <= newFlags.z;
      if (aluReq.op != cma_pkg::ALU_LOGIC)
      begin
        flags_reg.dc <= newFlags.dc;
        flags_reg.c <= newFlags.c;
      end
    end
    else if (coreWr && `CMA_OFF_W'(effRef.idx) == `CMA_CORE_STATUS)
      flags_reg <= fileReq.wdata[2:0];
  end
  assign statusVal = {3'b000, to_reg, pd_reg, flags_reg};

  // Banked and common RAM; program memory never written here
  always_ff @(posedge clk_sys)
  begin
    if (wrGo && effRef.region == cma_pkg::REG_GPR)
      gprMem[effRef.idx] <= fileReq.wdata;
    if (wrGo && effRef.region == cma_pkg::REG_COMMON)
      comMem[`CMA_NIB_W'(effRef.idx)] <= fileReq.wdata;
  end

  // Read selection
  always_comb
  begin
    readMux = 8'h00;
    case (effRef.region)
      cma_pkg::REG_CORE:
      begin
        case (`CMA_OFF_W'(effRef.idx))
          `CMA_CORE_PCL: readMux = pc_reg[7:0];
          `CMA_CORE_STATUS: readMux = statusVal;
          `CMA_CORE_FSR0L: readMux = fsr0_reg[7:0];
          `CMA_CORE_FSR0H: readMux = fsr0_reg[15:8];
          `CMA_CORE_FSR1L: readMux = fsr1_reg[7:0];
          `CMA_CORE_FSR1H: readMux = fsr1_reg[15:8];
          `CMA_CORE_BSR: readMux = `CMA_DATA_W'(bsr_reg);
          `CMA_CORE_WORKING_REG: readMux = working_reg_reg;
          `CMA_CORE_PCLATH: readMux = pclath_reg;
          `CMA_CORE_INTCON: readMux = intcon_reg;
          default: readMux = 8'h00;
        endcase
      end
      cma_pkg::REG_GPR: readMux = gprMem[effRef.idx];
      cma_pkg::REG_COMMON: readMux = comMem[`CMA_NIB_W'(effRef.idx)];
      cma_pkg::REG_PROG: readMux = progData[`CMA_DATA_W-1:0];
      default: readMux = 8'h00;
    endcase
  end

  // Read data lands one edge after an unstalled read
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      fileRdata <= 8'h00;
    else if (fileReq.re && fileGo)
      fileRdata <= readMux;
  end

  // Stack error flags; a new error wins over a software clear
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      ovf_reg <= 1'b0;
      unf_reg <= 1'b0;
      stkRstEn_reg <= 1'b0;
      stackResetReq <= 1'b0;
    end
    else
    begin
      if (ovfEvt)
        ovf_reg <= 1'b1;
      else if (apbWr && paddr == `CMA_APB_POWER_CONTROL_REG && !pwdata[`CMA_POWER_CONTROL_REG_OVF])
        ovf_reg <= 1'b0;
      if (unfEvt)
        unf_reg <= 1'b1;
      else if (apbWr && paddr == `CMA_APB_POWER_CONTROL_REG && !pwdata[`CMA_POWER_CONTROL_REG_UNF])
        unf_reg <= 1'b0;
      if (apbWr && paddr == `CMA_APB_POWER_CONTROL_REG)
        stkRstEn_reg <= pwdata[`CMA_POWER_CONTROL_REG_RSTEN];
      stackResetReq <= (ovfEvt || unfEvt) && stkRstEn_reg;
    end
  end

  // APB: data captured at setup, answer in the first access cycle
  assign apbWr = psel && penable && pwrite;
  assign pready = 1'b1;

  always_comb
  begin
    apbMapped = 1'b1;
    apbMux = 32'h0000_0000;
    case (paddr)
      `CMA_APB_STATUS: apbMux = 32'(statusVal);
      `CMA_APB_POWER_CONTROL_REG: apbMux = 32'({stkRstEn_reg, unf_reg, ovf_reg});
      `CMA_APB_PC: apbMux = 32'(pc_reg);
      `CMA_APB_FSR: apbMux = {fsr1_reg, fsr0_reg};
      `CMA_APB_BANK: apbMux = 32'({bsr_reg, working_reg_reg});
      default: apbMapped = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (psel && !penable)
    begin
      prdata <= pwrite ? 32'h0000_0000 : apbMux;
      pslverr <= !apbMapped;
    end
  end

endmodule : cma_core_mem
`default_nettype wire

// file: dv/cma_prog_model.sv
// Purpose: program flash seen by the core, read only
// Assumes: combinational read on progAddr
// Notes: data pattern differs per byte lane to expose lane slips
`timescale 1ns/1ps
`default_nettype none
module cma_prog_model (
  // Fetch port
  input wire logic [12:0] progAddr,
  output logic [13:0] progData
);
  // Upper six bits differ from the low byte on purpose
  assign progData = {progAddr[12:7], ~progAddr[7:0]};
endmodule : cma_prog_model
`default_nettype wire

// file: dv/cma_core_mem_checker.sv
// Purpose: port-level checks of the core memory block
// Assumes: one clock, rstn async active low
// Notes: status reads are tied back to the event that set them
`include "cma_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module cma_core_mem_checker (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Core side
  input wire logic clrwdtExec,
  input wire logic sleepExec,
  input wire logic wdtTimeout,
  input wire logic stackResetReq,
  input wire cma_pkg::cma_pc_op_t pcOp,
  input wire logic [`CMA_PC_W-1:0] pcTarget,
  input wire logic [`CMA_PC_W-1:0] pcValue,
  input wire logic [`CMA_PM_AW-1:0] progAddr,
  input wire cma_pkg::cma_file_req_t fileReq,
  input wire logic [`CMA_DATA_W-1:0] fileRdata,
  input wire logic fileStall,
  input wire logic [`CMA_DATA_W-1:0] workReg,
  input wire cma_pkg::cma_alu_req_t aluReq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // Steps from an event to the read that reports it
  sequence statusRd;
    fileReq.re && fileReq.addr == 7'h03 && !fileStall;
  endsequence
  sequence sleepRd;
    sleepExec && !wdtTimeout ##1 !wdtTimeout && !clrwdtExec ##1 statusRd;
  endsequence
  sequence wdtRd;
    wdtTimeout ##1 !clrwdtExec && !sleepExec ##1 statusRd;
  endsequence
  sequence aluRd;
    aluReq.en ##1 !aluReq.en && !fileReq.we ##1 statusRd;
  endsequence
  a_irq_vector: assert property (pcOp == cma_pkg::PC_IRQ && !fileStall
    |=> pcValue == 15'h0004)
    else $error("irq vector wrong");
  a_reset_start: assert property ($rose(rstn) |-> pcValue == 15'h0000)
    else $error("reset start address wrong");
  a_pc_wrap: assert property (!fileReq.re |-> progAddr == pcValue[12:0])
    else $error("program address not wrapped pc");
  a_jump_target: assert property (pcOp == cma_pkg::PC_JUMP && !fileStall
    |=> pcValue == $past(pcTarget))
    else $error("jump target lost");
  a_stall_single: assert property (fileStall |=> !fileStall)
    else $error("stall longer than one cycle");
  a_stall_holds: assert property (fileStall |=> $stable(pcValue))
    else $error("pc moved during stall");
  a_status_top: assert property (statusRd |=> fileRdata[7:5] == 3'b000)
    else $error("status top bits set");
  a_sleep_flags: assert property (sleepRd |=> fileRdata[4:3] == 2'b10)
    else $error("sleep flags wrong");
  a_wdt_clears: assert property (wdtRd |=> !fileRdata[4])
    else $error("timeout flag not cleared");
  a_zero_flag: assert property (aluRd
    |=> fileRdata[2] == ($past(aluReq.result, 3) == 8'h00))
    else $error("zero flag wrong");
  a_stack_pulse: assert property (stackResetReq |=> !stackResetReq)
    else $error("stack reset request too long");
  a_working_reg_core: assert property (fileReq.we && fileReq.addr == 7'h09 && !fileStall
    |=> workReg == $past(fileReq.wdata))
    else $error("working register not written");
endmodule : cma_core_mem_checker
bind cma_core_mem cma_core_mem_checker chk (.clk_sys, .rstn, .clrwdtExec, .sleepExec,
  .wdtTimeout, .stackResetReq, .pcOp, .pcTarget, .pcValue, .progAddr, .fileReq,
  .fileRdata, .fileStall, .workReg, .aluReq);
`default_nettype wire

// file: dv/test_cma_core_mem.sv
// Purpose: directed bench for the core memory block
// Assumes: zero-wait APB, flash model answers combinationally
// Notes: each request starts one edge after the previous one ends
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin nMismatch++; \
  $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module test_cma_core_mem;
  logic clk_sys, rstn, softReset, clrwdtExec, sleepExec, wdtTimeout, stackResetReq;
  logic fileStall, psel, penable, pwrite, pready, pslverr, apbErr;
  cma_pkg::cma_pc_op_t pcOp;
  logic [14:0] pcTarget, pcValue;
  logic [12:0] progAddr;
  logic [13:0] progData;
  cma_pkg::cma_file_req_t fileReq;
  cma_pkg::cma_alu_req_t aluReq;
  logic [7:0] fileRdata, workReg, paddr;
  logic [31:0] pwdata, prdata, apbData;
  int nMismatch, comparisons, stallCnt, nStackRst, i;
  cma_core_mem DUT (.clk_sys, .rstn, .softReset, .clrwdtExec, .sleepExec, .wdtTimeout,
    .stackResetReq, .pcOp, .pcTarget, .pcValue, .progAddr, .progData, .fileReq, .fileRdata,
    .fileStall, .workReg, .aluReq, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr);
  cma_prog_model flash (.progAddr, .progData);
  // Free-running 100 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Stack error requests seen
  always @(posedge clk_sys)
    if (stackResetReq === 1'b1)
      nStackRst++;
  task automatic endOfTest;
    $display("comparisons %0d mismatches %0d", comparisons, nMismatch);
    if (nMismatch == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : endOfTest
  // File access held until taken; stall cycles counted
  task automatic fa(input logic w, input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    fileReq <= '{re: !w, we: w, addr: a, wdata: d};
    stallCnt = 0;
    @(negedge clk_sys);
    while (fileStall)
    begin
      stallCnt++;
      @(negedge clk_sys);
    end
    @(posedge clk_sys);
    fileReq <= '0;
    @(negedge clk_sys);
  endtask : fa
  task automatic fr(input logic [6:0] a, input logic [7:0] e);
    fa(1'b0, a, 8'h00);
    `CHK(fileRdata, e)
  endtask : fr
  task automatic pc(input cma_pkg::cma_pc_op_t op, input logic [14:0] t);
    @(posedge clk_sys);
    pcOp <= op;
    pcTarget <= t;
    @(posedge clk_sys);
    pcOp <= cma_pkg::PC_HOLD;
    @(negedge clk_sys);
  endtask : pc
  // Event pulses {watchdog_clear_instr, sleep, watchdog}
  task automatic ev(input logic [2:0] v);
    @(posedge clk_sys);
    {clrwdtExec, sleepExec, wdtTimeout} <= v;
    @(posedge clk_sys);
    {clrwdtExec, sleepExec, wdtTimeout} <= 3'b000;
  endtask : ev
  task automatic alu(input cma_pkg::cma_alu_op_t op, input logic [7:0] a, b, r);
    @(posedge clk_sys);
    aluReq <= '{1'b1, op, a, b, r};
    @(posedge clk_sys);
    aluReq <= '0;
  endtask : alu
  // APB transfer; request held until pready is sampled high
  task automatic ap(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (!pready)
      @(posedge clk_sys);
    apbData = prdata;
    apbErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : ap
  task automatic tReset;
    @(negedge clk_sys);
    `CHK(pcValue, 15'h0000)
    ap(1'b0, 8'h00, 32'h0);
    `CHK(apbData, 32'h0000_0018)
    fr(7'h03, 8'h18);
    ap(1'b0, 8'h14, 32'h0);
    `CHK({apbErr, apbData}, {1'b1, 32'h0})
    $display("reset test done");
  endtask : tReset
  task automatic tPc;
    pc(cma_pkg::PC_INC, 15'h0000);
    `CHK(pcValue, 15'h0001)
    pc(cma_pkg::PC_IRQ, 15'h0000);
    `CHK(pcValue, 15'h0004)
    pc(cma_pkg::PC_RET, 15'h0000);
    `CHK(pcValue, 15'h0001)
    pc(cma_pkg::PC_JUMP, 15'h7FF0);
    `CHK(progAddr, 13'h1FF0)
    fr(7'h02, 8'hF0);
    ap(1'b0, 8'h08, 32'h0);
    `CHK(apbData, 32'h0000_7FF0)
    ap(1'b1, 8'h04, 32'h4);
    for (i = 0; i < 17; i++)
      pc(cma_pkg::PC_CALL, 15'h0100 + 15'(i));
    `CHK(pcValue, 15'h0110)
    ap(1'b0, 8'h04, 32'h0);
    `CHK(apbData, 32'h5)
    ap(1'b1, 8'h04, 32'h4);
    pc(cma_pkg::PC_RET, 15'h0000);
    `CHK(pcValue, 15'h010F)
    for (i = 0; i < 15; i++)
      pc(cma_pkg::PC_RET, 15'h0000);
    `CHK({pcValue, progAddr}, {15'h7FF1, 13'h1FF1})
    pc(cma_pkg::PC_RET, 15'h0000);
    ap(1'b0, 8'h04, 32'h0);
    `CHK(apbData, 32'h6)
    `CHK(nStackRst, 2)
    $display("stack test done");
  endtask : tPc
  task automatic tBank;
    fa(1'b1, 7'h08, 8'h01);
    fa(1'b1, 7'h20, 8'hA5);
    fa(1'b1, 7'h08, 8'h02);
    fa(1'b1, 7'h20, 8'h5A);
    fa(1'b1, 7'h70, 8'h3C);
    fa(1'b1, 7'h0B, 8'h5A);
    fa(1'b1, 7'h0A, 8'hC6);
    fa(1'b1, 7'h09, 8'h77);
    `CHK(workReg, 8'h77)
    fa(1'b1, 7'h08, 8'h01);
    fr(7'h20, 8'hA5);
    `CHK(stallCnt, 0)
    fr(7'h70, 8'h3C);
    fr(7'h0C, 8'h00);
    fr(7'h09, 8'h77);
    fr(7'h0B, 8'h5A);
    fr(7'h0A, 8'hC6);
    ap(1'b0, 8'h10, 32'h0);
    `CHK(apbData, 32'h0000_0177)
    $display("bank test done");
  endtask : tBank
  task automatic tInd;
    fa(1'b1, 7'h04, 8'h00);
    fa(1'b1, 7'h05, 8'h20);
    fa(1'b1, 7'h00, 8'hC3);
    fa(1'b1, 7'h06, 8'hA0);
    fa(1'b1, 7'h07, 8'h00);
    fr(7'h01, 8'hA5);
    fa(1'b1, 7'h08, 8'h00);
    fr(7'h20, 8'hC3);
    fa(1'b1, 7'h04, 8'h50);
    fr(7'h00, 8'hA5);
    fa(1'b1, 7'h06, 8'h23);
    fa(1'b1, 7'h07, 8'h81);
    fr(7'h01, 8'hDC);
    `CHK(stallCnt, 1)
    fa(1'b1, 7'h01, 8'h00);
    fr(7'h01, 8'hDC);
    ap(1'b0, 8'h0C, 32'h0);
    `CHK(apbData, 32'h8123_2050)
    $display("pointer test done");
  endtask : tInd
  task automatic tStat;
    alu(cma_pkg::ALU_ADD, 8'h0F, 8'h01, 8'h10);
    fr(7'h03, 8'h1A);
    alu(cma_pkg::ALU_ADD, 8'h80, 8'h80, 8'h00);
    fr(7'h03, 8'h1D);
    alu(cma_pkg::ALU_LOGIC, 8'h0F, 8'h01, 8'h01);
    fr(7'h03, 8'h19);
    alu(cma_pkg::ALU_SUB, 8'h05, 8'h05, 8'h00);
    fr(7'h03, 8'h1F);
    alu(cma_pkg::ALU_SUB, 8'h03, 8'h05, 8'hFE);
    fr(7'h03, 8'h18);
    fa(1'b1, 7'h03, 8'hFF);
    fr(7'h03, 8'h1F);
    // Flag write and flag-setting operation in the same cycle
    @(posedge clk_sys);
    fileReq <= '{re: 1'b0, we: 1'b1, addr: 7'h03, wdata: 8'h00};
    aluReq <= '{1'b1, cma_pkg::ALU_LOGIC, 8'h00, 8'h00, 8'h00};
    @(posedge clk_sys);
    fileReq <= '0;
    aluReq <= '0;
    fr(7'h03, 8'h1F);
    $display("status test done");
  endtask : tStat
  task automatic tEvt;
    ev(3'b010);
    fr(7'h03, 8'h17);
    fa(1'b1, 7'h03, 8'hFF);
    fr(7'h03, 8'h17);
    ev(3'b001);
    fr(7'h03, 8'h07);
    ap(1'b1, 8'h00, 32'hFF);
    ap(1'b0, 8'h00, 32'h0);
    `CHK(apbData, 32'h07)
    ev(3'b100);
    fr(7'h03, 8'h1F);
    pc(cma_pkg::PC_JUMP, 15'h0055);
    @(posedge clk_sys);
    softReset <= 1'b1;
    @(posedge clk_sys);
    softReset <= 1'b0;
    @(negedge clk_sys);
    `CHK(pcValue, 15'h0000)
    fr(7'h03, 8'h1F);
    $display("event test done");
  endtask : tEvt
  // Hang guard, far beyond the few hundred cycles used
  initial
  begin
    #100000;
    nMismatch++;
    endOfTest();
  end
  // Main sequence
  initial
  begin
    {rstn, softReset, clrwdtExec, sleepExec, wdtTimeout, psel, penable, pwrite} = 8'h00;
    pcOp = cma_pkg::PC_HOLD;
    pcTarget = 15'h0000;
    fileReq = '0;
    aluReq = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    tReset();
    tPc();
    tBank();
    tInd();
    tStat();
    tEvt();
    endOfTest();
  end
endmodule : test_cma_core_mem
`default_nettype wire
